/* src/rrt_defines.vh */
`ifndef RRT_DEFINES_VH
`define RRT_DEFINES_VH

// Clock period in picoseconds (100 MHz)
`define RRT_CLK_PERIOD_PS 10000
// Trip evaluation window after each sync rising edge seen in idle, in microseconds
`define RRT_EVAL_WINDOW_US 20
// Integrator clear time after the window, in microseconds
`define RRT_CLEAR_TIME_US 100
// Longest evaluation window rounds down to whole cycles
`define RRT_EVAL_CYCLES ((`RRT_EVAL_WINDOW_US * 1000000) / `RRT_CLK_PERIOD_PS)
// Least clear time rounds up to whole cycles
`define RRT_CLEAR_CYCLES (((`RRT_CLEAR_TIME_US * 1000000) + `RRT_CLK_PERIOD_PS - 1) / `RRT_CLK_PERIOD_PS)
// Integrator accumulator width and trip threshold
`define RRT_ACC_WIDTH 24
`define RRT_TRIP_THRESHOLD 24'h000010
// Ring cycles allowed for a trip response in the worst case
`define RRT_MAX_TRIP_CYCLES 3

`endif

/* src/rrt_edge_sync.v */
`timescale 1ns/100ps
`default_nettype none

// Registers a level and reports its rising and falling edges
module rrt_edge_sync (
  input wire clk_i,
  input wire nrst_i,
  input wire level_i,
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);

  reg prev;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev <= 1'b0;
    end else begin
      prev <= level_i;
    end
  end

  assign level_o = prev;
  assign rise_o = level_i & ~prev;
  assign fall_o = ~level_i & prev;

endmodule // rrt_edge_sync

`default_nettype wire

/* src/rrt_ring_trip.v */
// Contract
// - Request latch follows ring request while strobe is high.
// - Request latch holds ring request value from strobe falling edge.
// - Relay flip-flop loads latch output only on sync rising edges.
// - Off-hook means comparator high under half of one ringing cycle.
// - A detected trip clears latch and relay at the next sync rise.
// - Each sync rising edge in idle opens a 20 us evaluation window; edges during window or clear are ignored.
// - After the window the integrator is held at zero for 100 us.
// - Detection takes one ring cycle; worst-case trip response within three cycles.
// - Detection uses one cycle, reset is produced on the second cycle.
`timescale 1ns/100ps
`default_nettype none
`include "rrt_defines.vh"

module rrt_ring_trip #(
  parameter ACC_WIDTH = `RRT_ACC_WIDTH,
  parameter EVAL_CYCLES = `RRT_EVAL_CYCLES,
  parameter CLEAR_CYCLES = `RRT_CLEAR_CYCLES
) (
  input wire clk_i,
  input wire nrst_i,
  input wire ring_request_i,
  input wire strobe_i,
  input wire zero_cross_sync_i,
  input wire loop_current_comparator_i,
  input wire trip_disable_i,
  output wire ring_relay_o,
  output wire request_latched_o,
  output wire eval_window_o,
  output wire integrator_discharge_switch_o,
  output wire trip_threshold_comparator_o,
  output wire trip_reset_o
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EVAL = 3'b010;
  localparam [2:0] ST_CLEAR = 3'b100;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on the sync input

  wire sync_rise;

  rrt_edge_sync u_sync_edge (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .level_i(zero_cross_sync_i),
    .level_o(),
    .rise_o(sync_rise),
    .fall_o()
  );

  ////////////////////////////////////////////////////////////////////////
  // Trip evaluation sequencer

  reg [2:0] state;
  reg [2:0] next_state;
  reg [16:0] timer;
  reg [16:0] next_timer;
  reg trip_pending;
  reg trip_reset;
  reg signed [ACC_WIDTH-1:0] trip_integrator_cap;

  wire signed [ACC_WIDTH-1:0] threshold = `RRT_TRIP_THRESHOLD;
  // Integrator grounded: no charge, no trip
  wire trip_above = ~trip_disable_i && (trip_integrator_cap > threshold);
  wire in_eval = (state == ST_EVAL);
  wire in_clear = (state == ST_CLEAR);

  always @* begin
    next_state = state;
    next_timer = timer;
    case (state)
      ST_IDLE: begin
        if (sync_rise) begin
          next_state = ST_EVAL;
          next_timer = EVAL_CYCLES[16:0] - 17'h00001;
        end
      end
      ST_EVAL: begin
        if (timer == 17'h00000) begin
          next_state = ST_CLEAR;
          next_timer = CLEAR_CYCLES[16:0] - 17'h00001;
        end else begin
          next_timer = timer - 17'h00001;
        end
      end
      ST_CLEAR: begin
        if (timer == 17'h00000) begin
          next_state = ST_IDLE;
        end else begin
          next_timer = timer - 17'h00001;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_timer = 17'h00000;
      end
    endcase
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
      timer <= 17'h00000;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Up/down integrator of the loop current comparator

  // Saturating limits keep a stalled sync from wrapping the count
  localparam [ACC_WIDTH-1:0] ACC_MAX = {1'b0, {(ACC_WIDTH-1){1'b1}}};
  localparam [ACC_WIDTH-1:0] ACC_MIN = {1'b1, {(ACC_WIDTH-1){1'b0}}};
  localparam [ACC_WIDTH-1:0] ACC_ONE = {{(ACC_WIDTH-1){1'b0}}, 1'b1};

  reg signed [ACC_WIDTH-1:0] next_integrator;

  // Held during the window so the judgement sees the count from the end of clear to the sync rise
  always @* begin
    next_integrator = trip_integrator_cap;
    if (in_clear || trip_disable_i) begin
      next_integrator = {ACC_WIDTH{1'b0}};
    end else if (!in_eval) begin
      if (loop_current_comparator_i) begin
        // Comparator high: loop current below threshold, count down
        if (trip_integrator_cap != ACC_MIN) begin
          next_integrator = trip_integrator_cap - ACC_ONE;
        end
      end else begin
        // Comparator low: loop current above threshold, count up
        if (trip_integrator_cap != ACC_MAX) begin
          next_integrator = trip_integrator_cap + ACC_ONE;
        end
      end
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trip_integrator_cap <= {ACC_WIDTH{1'b0}};
    end else begin
      trip_integrator_cap <= next_integrator;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trip decision: judged in the window, reset at the next sync rise

  reg next_trip_pending;

  always @* begin
    next_trip_pending = trip_pending;
    if (sync_rise && trip_pending) begin
      next_trip_pending = 1'b0;
    end
    // A judgement in the same cycle as the firing edge is kept
    if (in_eval && trip_above) begin
      next_trip_pending = 1'b1;
    end
    // Grounded integrator: automatic trip is off
    if (trip_disable_i) begin
      next_trip_pending = 1'b0;
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trip_pending <= 1'b0;
      trip_reset <= 1'b0;
    end else begin
      trip_pending <= next_trip_pending;
      trip_reset <= sync_rise & trip_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request latch and relay flip-flop

  reg request_latch;
  reg ring_relay;
  // Trip clear wins over a strobe load in the same cycle
  wire trip_now = sync_rise & trip_pending;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      request_latch <= 1'b0;
    end else if (trip_now) begin
      request_latch <= 1'b0;
    end else if (strobe_i) begin
      request_latch <= ring_request_i;
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ring_relay <= 1'b0;
    end else if (trip_now) begin
      ring_relay <= 1'b0;
    end else if (sync_rise) begin
      ring_relay <= request_latch;
    end
  end

  assign ring_relay_o = ring_relay;
  assign request_latched_o = request_latch;
  assign eval_window_o = in_eval;
  assign integrator_discharge_switch_o = in_clear;
  assign trip_threshold_comparator_o = in_eval & trip_above;
  assign trip_reset_o = trip_reset;

endmodule // rrt_ring_trip

`default_nettype wire

/* verification/rrt_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module rrt_checker #(parameter EVAL_CYCLES = 4, parameter CLEAR_CYCLES = 8) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ring_request_i,
  input wire logic strobe_i,
  input wire logic zero_cross_sync_i,
  input wire logic loop_current_comparator_i,
  input wire logic trip_disable_i,
  input wire logic ring_relay_o,
  input wire logic request_latched_o,
  input wire logic eval_window_o,
  input wire logic integrator_discharge_switch_o,
  input wire logic trip_threshold_comparator_o,
  input wire logic trip_reset_o
);
  logic prev;
  wire rise = zero_cross_sync_i && !prev;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) prev <= 1'b0;
    else prev <= zero_cross_sync_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_latch_follow: assert property (strobe_i && !rise |=> request_latched_o == $past(ring_request_i))
    else $error("latch did not follow request");
  a_latch_hold: assert property (!strobe_i && !rise |=> $stable(request_latched_o))
    else $error("latch changed with strobe low");
  a_relay_still: assert property (!rise |=> $stable(ring_relay_o))
    else $error("relay moved without sync rise");
  a_relay_load: assert property (rise |=> ring_relay_o == $past(request_latched_o) || trip_reset_o)
    else $error("relay did not load latch");
  a_trip_clears: assert property (trip_reset_o |-> !ring_relay_o && !request_latched_o)
    else $error("trip left latch or relay set");
  a_trip_on_rise: assert property (trip_reset_o |-> $past(zero_cross_sync_i) && !$past(zero_cross_sync_i, 2))
    else $error("trip not at sync rise");
  a_window_len: assert property ($rose(eval_window_o) |-> eval_window_o [*4] ##1 !eval_window_o)
    else $error("window length wrong");
  a_window_start: assert property (rise && !eval_window_o && !integrator_discharge_switch_o |=> eval_window_o)
    else $error("window not opened");
  a_clear_len: assert property ($fell(eval_window_o) |-> integrator_discharge_switch_o [*8] ##1 !integrator_discharge_switch_o)
    else $error("clear period wrong");
  a_cmp_window: assert property (trip_threshold_comparator_o |-> eval_window_o)
    else $error("threshold outside window");
endmodule // rrt_checker
bind rrt_ring_trip rrt_checker #(.EVAL_CYCLES(EVAL_CYCLES), .CLEAR_CYCLES(CLEAR_CYCLES)) chk (.*);
`default_nettype wire

/* verification/rrt_line_model.sv */
`timescale 1ns/100ps
`default_nettype none
module rrt_line_model (
  input wire logic clk_i,
  input wire logic off_hook_i,
  output logic sync_o = 1'b0,
  output logic comp_o = 1'b1
);
  int cnt = 0;
  always @(negedge clk_i) begin
    cnt <= (cnt == 79) ? 0 : cnt + 1;
    sync_o <= cnt < 40;
    comp_o <= off_hook_i ? cnt >= 60 : cnt >= 20;
  end
endmodule // rrt_line_model
`default_nettype wire

/* verification/rrt_ring_trip_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module rrt_ring_trip_tb;
  logic clk_i = 0, nrst_i = 0, req = 0, stb = 0, dis = 0, hook = 0, seen_thr = 0;
  wire sync, comp, relay, lat, win, dsc, thr, trp;
  int n_mismatch = 0, check_count = 0, i;
  always #5 clk_i = ~clk_i;
  rrt_line_model far (.clk_i(clk_i), .off_hook_i(hook), .sync_o(sync), .comp_o(comp));
  rrt_ring_trip #(.EVAL_CYCLES(4), .CLEAR_CYCLES(8)) uut (.clk_i(clk_i), .nrst_i(nrst_i),
    .ring_request_i(req), .strobe_i(stb), .zero_cross_sync_i(sync), .loop_current_comparator_i(comp),
    .trip_disable_i(dis), .ring_relay_o(relay), .request_latched_o(lat), .eval_window_o(win),
    .integrator_discharge_switch_o(dsc), .trip_threshold_comparator_o(thr), .trip_reset_o(trp));
  task automatic waitn(int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_latch;
    stb = 1; req = 1; waitn(2);
    `CHK(lat, 1'b1)
    req = 0; waitn(2);
    `CHK(lat, 1'b0)
    stb = 0; req = 1; waitn(2);
    `CHK(lat, 1'b0)
  endtask
  task automatic t_window;
    i = 0;
    while (win !== 1'b0 && i < 100) begin
      waitn(1); i++;
    end
    while (win !== 1'b1 && i < 200) begin
      waitn(1); i++;
    end
    `CHK(win, 1'b1)
    `CHK(dsc, 1'b0)
    waitn(4);
    `CHK({win, dsc}, 2'h1)
    waitn(7);
    `CHK(dsc, 1'b1)
    waitn(1);
    `CHK(dsc, 1'b0)
  endtask
  task automatic t_ring;
    stb = 1; waitn(1);
    stb = 0; req = 0; waitn(90);
    `CHK(relay, 1'b1)
    waitn(240);
    `CHK(relay, 1'b1)
  endtask
  task automatic t_trip;
    hook = 1; i = 0; seen_thr = 0;
    while (trp !== 1'b1 && i < 240) begin
      waitn(1); i++;
      if (thr === 1'b1) seen_thr = 1;
    end
    `CHK(trp, 1'b1)
    `CHK(seen_thr, 1'b1)
    `CHK(i >= 80, 1'b1)
    `CHK({relay, lat}, 2'h0)
    hook = 0;
  endtask
  task automatic t_disable;
    dis = 1; stb = 1; req = 1; waitn(1);
    stb = 0; req = 0; hook = 1; waitn(330);
    `CHK(relay, 1'b1)
    dis = 0; hook = 0;
  endtask
  initial begin
    waitn(12);
    nrst_i = 1;
    t_latch; t_window; t_ring; t_trip; t_disable;
    report_and_stop;
  end
  initial begin
    #30000;
    n_mismatch++;
    report_and_stop;
  end
endmodule // rrt_ring_trip_tb
`default_nettype wire
